// ### bench/mtf_core_model.sv
// Purpose: Trap-side model of the core issuing fault reports
// Assumes: Reports driven 1 ns after the rising edge, one cycle each
// Notes:   Idle kind, ASI, context, E and write fields carry inverted junk; the other fields keep stale values
`timescale 1ns/1ps

module mtf_core_model
	import mtf_pkg::*;
(
	// Clock
	input  wire logic         clk,
	// Fault report
	output logic              flt_valid,
	output logic              flt_dmmu,
	output mtf_trap_type      flt_trap,
	output logic      [6:0]   flt_kind,
	output logic              flt_alt,
	output logic      [7:0]   flt_asi,
	output logic              flt_tl_nonzero,
	output logic              flt_jmpl_misalign,
	output logic              flt_cle,
	output logic              flt_tte_e,
	output logic              flt_bypass,
	output logic              flt_pa39,
	output logic              flt_internal,
	output logic      [1:0]   flt_ctx,
	output logic              flt_write
);
	initial begin
		flt_valid = 1'b0;
		{flt_dmmu, flt_kind, flt_alt, flt_asi, flt_tl_nonzero, flt_jmpl_misalign} = '0;
		{flt_cle, flt_tte_e, flt_bypass, flt_pa39, flt_internal, flt_ctx, flt_write} = '0;
		flt_trap = MTF_TRAP_OTHER;
	end

	// ****************************************************
	// One fault report, nucleus space when not alternate
	// ****************************************************
	task automatic report(input logic dm, input mtf_trap_type tr, input logic [6:0] k,
		input logic [7:0] a, input logic alt, input logic e, input logic [1:0] c,
		input logic w);
		@(posedge clk);
		#1;
		flt_dmmu = dm;
		flt_trap = tr;
		flt_kind = k;
		flt_asi = a;
		flt_alt = alt;
		flt_tl_nonzero = ~alt;
		flt_tte_e = e;
		flt_ctx = c;
		flt_write = w;
		flt_valid = 1'b1;
		@(posedge clk);
		#1;
		flt_valid = 1'b0;
		flt_kind = ~k;
		flt_asi = ~a;
		flt_ctx = ~c;
		flt_tte_e = ~e;
		flt_write = ~w;
	endtask : report
endmodule : mtf_core_model

// ### bench/mtf_mmu_regs_tb.sv
// Purpose: Self-checking bench for the MMU context, TSB and fault status registers
// Assumes: One access per call, answer one cycle after the request
// Notes:   Fault reports come from the core model
`timescale 1ns/1ps
`include "mtf_regs.svh"

module mtf_mmu_regs_tb
	import mtf_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic asi_valid = 1'b0;
	logic asi_write = 1'b0;
	logic [7:0] asi_num = 8'h00;
	logic [63:0] asi_va = '0;
	logic [63:0] asi_wdata = '0;
	logic [63:0] asi_rdata;
	logic asi_done, asi_misalign, asi_illegal;
	logic [63:0] d_tag_va = 64'h0000_0000_0052_6000;
	logic [12:0] d_tag_ctx = 13'h0000;
	logic [63:0] i_tag_va = 64'h0000_0000_0000_4000;
	logic [12:0] i_tag_ctx = 13'h0005;
	logic flt_valid, flt_dmmu, flt_alt, flt_tl_nonzero, flt_jmpl_misalign, flt_cle;
	logic flt_tte_e, flt_bypass, flt_pa39, flt_internal, flt_write;
	mtf_trap_type flt_trap;
	logic [6:0] flt_kind;
	logic [7:0] flt_asi;
	logic [1:0] flt_ctx;
	logic [12:0] pctx, sctx;
	logic [63:0] rd_q;
	logic mis_q, ill_q;
	int n_errors = 0;
	int tests_run = 0;
	logic [2:0] ps;

	always #25 clk = ~clk;

	mtf_mmu_regs uut (.clk(clk), .sys_rst(sys_rst), .asi_valid(asi_valid),
		.asi_write(asi_write), .asi_num(asi_num), .asi_va(asi_va), .asi_wdata(asi_wdata),
		.asi_rdata(asi_rdata), .asi_done(asi_done), .asi_misalign(asi_misalign),
		.asi_illegal(asi_illegal), .i_tag_va(i_tag_va), .i_tag_ctx(i_tag_ctx),
		.d_tag_va(d_tag_va), .d_tag_ctx(d_tag_ctx), .flt_valid(flt_valid),
		.flt_dmmu(flt_dmmu), .flt_trap(flt_trap), .flt_kind(flt_kind), .flt_alt(flt_alt),
		.flt_asi(flt_asi), .flt_tl_nonzero(flt_tl_nonzero),
		.flt_jmpl_misalign(flt_jmpl_misalign), .flt_cle(flt_cle), .flt_tte_e(flt_tte_e),
		.flt_bypass(flt_bypass), .flt_pa39(flt_pa39), .flt_internal(flt_internal),
		.flt_ctx(flt_ctx), .flt_write(flt_write), .pctx(pctx), .sctx(sctx));

	mtf_core_model core (.clk(clk), .flt_valid(flt_valid), .flt_dmmu(flt_dmmu),
		.flt_trap(flt_trap), .flt_kind(flt_kind), .flt_alt(flt_alt), .flt_asi(flt_asi),
		.flt_tl_nonzero(flt_tl_nonzero), .flt_jmpl_misalign(flt_jmpl_misalign),
		.flt_cle(flt_cle), .flt_tte_e(flt_tte_e), .flt_bypass(flt_bypass),
		.flt_pa39(flt_pa39), .flt_internal(flt_internal), .flt_ctx(flt_ctx),
		.flt_write(flt_write));

	// ****************************************************
	// Checking and access tasks
	// ****************************************************
	task automatic report_and_stop;
		$display("Checks run %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk

	task automatic acc(input logic w, input logic [7:0] n, input logic [63:0] va,
		input logic [63:0] d);
		int k;
		k = 0;
		@(posedge clk);
		#1;
		asi_write = w;
		asi_num = n;
		asi_va = va;
		asi_wdata = d;
		asi_valid = 1'b1;
		@(posedge clk);
		#1;
		asi_valid = 1'b0;
		asi_wdata = ~d;
		asi_va = ~va;
		while (asi_done !== 1'b1 && k < 4) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == 4) begin
			chk("asi_done", 64'h1, 64'h0);
			report_and_stop();
		end
		rd_q = asi_rdata;
		mis_q = asi_misalign;
		ill_q = asi_illegal;
	endtask : acc

	task automatic rd(input logic [7:0] n, input logic [63:0] va, input logic [63:0] e);
		acc(1'b0, n, va, 64'h5a5a_5a5a_5a5a_5a5a);
		chk("asi_rdata", e, rd_q);
		chk("flags", 64'h0, {62'h0, mis_q, ill_q});
	endtask : rd

	task automatic wr(input logic [7:0] n, input logic [63:0] va, input logic [63:0] d,
		input logic [1:0] fl);
		acc(1'b1, n, va, d);
		chk("flags", {62'h0, fl}, {62'h0, mis_q, ill_q});
	endtask : wr

	function automatic logic [63:0] sx(input logic [7:0] a, input logic [6:0] k,
		input logic e, input logic [1:0] c, input logic w, input logic ow);
		return {40'h0, a, 2'b00, k, e, c, 1'b0, w, ow, 1'b1};
	endfunction : sx

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		repeat (5) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		rd(`MTF_ASI_CTX, `MTF_VA_PCTX, 64'h0);
		rd(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, 64'h0);
		wr(`MTF_ASI_CTX, `MTF_VA_PCTX, ~64'h0, 2'b00);
		rd(`MTF_ASI_CTX, `MTF_VA_PCTX, 64'h0000_0000_0000_1fff);
		chk("pctx", 64'h1fff, {51'h0, pctx});
		wr(`MTF_ASI_CTX, `MTF_VA_SCTX, 64'h0000_0000_1234_5678, 2'b00);
		rd(`MTF_ASI_CTX, `MTF_VA_SCTX, 64'h0000_0000_0000_1678);
		chk("sctx", 64'h1678, {51'h0, sctx});
		wr(`MTF_ASI_D_Z_B0, `MTF_VA_ZERO, 64'h0000_8000_0000_3f0f, 2'b00);
		rd(`MTF_ASI_D_Z_B0, `MTF_VA_ZERO, 64'hffff_8000_0000_300f);
		rd(`MTF_ASI_I_Z_B0, `MTF_VA_ZERO, 64'h0);
		// Write then read in the next cycle
		@(posedge clk);
		#1;
		asi_write = 1'b1;
		asi_num = `MTF_ASI_I_NZ_B1;
		asi_va = `MTF_VA_ZERO;
		asi_wdata = 64'h0000_8000_0000_2003;
		asi_valid = 1'b1;
		@(posedge clk);
		#1;
		asi_write = 1'b0;
		@(posedge clk);
		#1;
		asi_valid = 1'b0;
		chk("asi_rdata", 64'hffff_8000_0000_2003, asi_rdata);
		for (int c = 0; c < 8; c++) begin
			ps = (c == 0 || c == 1 || c == 3 || c == 5) ? 3'(c) : 3'h5;
			wr(`MTF_ASI_D_Z_CFG, `MTF_VA_ZERO, 64'hffff_ffff_ffff_f8f8 | (64'(c) * 64'h0101),
				2'b00);
			rd(`MTF_ASI_D_Z_CFG, `MTF_VA_ZERO, {53'h0, ps, 5'h00, ps});
		end
		wr(`MTF_ASI_D_Z_CFG, `MTF_VA_ZERO, 64'h0000_0000_0000_0100, 2'b00);
		wr(`MTF_ASI_D_Z_B0, `MTF_VA_ZERO, 64'h0000_0000_0040_0000, 2'b00);
		rd(`MTF_ASI_D_PTR0, `MTF_VA_ZERO, 64'h0000_0000_0040_0930);
		wr(`MTF_ASI_D_Z_B0, `MTF_VA_ZERO, 64'h0000_0000_0040_0001, 2'b00);
		rd(`MTF_ASI_D_PTR0, `MTF_VA_ZERO, 64'h0000_0000_0040_2930);
		wr(`MTF_ASI_D_Z_B1, `MTF_VA_ZERO, 64'h0000_0000_0040_1000, 2'b00);
		rd(`MTF_ASI_D_PTR1, `MTF_VA_ZERO, 64'h0000_0000_0040_2520);
		wr(`MTF_ASI_D_PTR0, `MTF_VA_ZERO, 64'h0, 2'b01);
		wr(`MTF_ASI_D_Z_B0, 64'h0000_0000_0000_0004, 64'h0, 2'b10);
		wr(8'h77, `MTF_VA_ZERO, 64'h0, 2'b01);
		rd(`MTF_ASI_D_PTR0, `MTF_VA_ZERO, 64'h0000_0000_0040_2930);
		for (int i = 0; i < 7; i++) begin
			wr(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, 64'h0, 2'b00);
			core.report(1'b1, MTF_TRAP_ACC_EXC, 7'(1 << i), 8'h80, 1'b1, 1'b0, 2'b00, 1'b0);
			rd(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, sx(8'h80, 7'(1 << i), 1'b0, 2'b00, 1'b0, 1'b0));
		end
		wr(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, 64'h0, 2'b00);
		core.report(1'b1, MTF_TRAP_ACC_EXC, 7'h08, 8'h80, 1'b1, 1'b1, 2'b01, 1'b1);
		rd(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, sx(8'h80, 7'h08, 1'b1, 2'b01, 1'b1, 1'b0));
		core.report(1'b1, MTF_TRAP_ACC_EXC, 7'h03, 8'h15, 1'b1, 1'b0, 2'b11, 1'b0);
		rd(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, sx(8'h15, 7'h03, 1'b1, 2'b11, 1'b0, 1'b1));
		core.report(1'b1, MTF_TRAP_MISS, 7'h08, 8'h80, 1'b1, 1'b1, 2'b01, 1'b1);
		rd(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, sx(8'h15, 7'h03, 1'b1, 2'b11, 1'b0, 1'b1));
		wr(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, 64'h0, 2'b00);
		rd(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, 64'h0);
		core.report(1'b1, MTF_TRAP_OTHER, 7'h08, 8'h80, 1'b0, 1'b0, 2'b10, 1'b0);
		rd(`MTF_ASI_D_MMU, `MTF_VA_SYNC_FAULT_STATUS, sx(8'h04, 7'h00, 1'b0, 2'b10, 1'b0, 1'b0));
		core.report(1'b0, MTF_TRAP_ACC_ERR, 7'h7f, 8'h80, 1'b1, 1'b1, 2'b00, 1'b1);
		rd(`MTF_ASI_I_MMU, `MTF_VA_SYNC_FAULT_STATUS, sx(8'h80, 7'h00, 1'b0, 2'b00, 1'b0, 1'b0));
		core.report(1'b0, MTF_TRAP_ACC_EXC, 7'h7f, 8'h80, 1'b1, 1'b1, 2'b00, 1'b1);
		rd(`MTF_ASI_I_MMU, `MTF_VA_SYNC_FAULT_STATUS, sx(8'h80, 7'h61, 1'b0, 2'b00, 1'b0, 1'b1));
		report_and_stop();
	end
endmodule : mtf_mmu_regs_tb

// ### rtl/mtf_mmu_regs.sv
// Purpose: Per-strand context, TSB base/config and fault status registers
// Assumes: One access and at most one fault per cycle; D index 0, I index 1
// Notes:   Answers come one cycle after the access is taken
`timescale 1ns/1ps
`include "mtf_regs.svh"

module mtf_mmu_regs
	import mtf_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          sys_rst,
	// Alternate-space access from the load-store unit
	input  wire logic          asi_valid,
	input  wire logic          asi_write,
	input  wire logic [7:0]    asi_num,
	input  wire logic [63:0]   asi_va,
	input  wire logic [63:0]   asi_wdata,
	output logic      [63:0]   asi_rdata,
	output logic               asi_done,
	output logic               asi_misalign,
	output logic               asi_illegal,
	// Tag access state for pointer formation
	input  wire logic [63:0]   i_tag_va,
	input  wire logic [12:0]   i_tag_ctx,
	input  wire logic [63:0]   d_tag_va,
	input  wire logic [12:0]   d_tag_ctx,
	// Fault report from trap logic
	input  wire logic          flt_valid,
	input  wire logic          flt_dmmu,
	input  wire mtf_trap_type  flt_trap,
	input  wire logic [6:0]    flt_kind,
	input  wire logic          flt_alt,
	input  wire logic [7:0]    flt_asi,
	input  wire logic          flt_tl_nonzero,
	input  wire logic          flt_jmpl_misalign,
	input  wire logic          flt_cle,
	input  wire logic          flt_tte_e,
	input  wire logic          flt_bypass,
	input  wire logic          flt_pa39,
	input  wire logic          flt_internal,
	input  wire logic [1:0]    flt_ctx,
	input  wire logic          flt_write,
	// Context numbers for translation
	output logic      [12:0]   pctx,
	output logic      [12:0]   sctx
);

	// ****************************************************
	// Helper functions
	// ****************************************************
	function automatic logic [63:0] sext47(input logic [63:0] x);
		sext47 = {{16{x[`MTF_SEXT_BIT]}}, x[`MTF_SEXT_BIT:0]};
	endfunction : sext47

	function automatic logic [2:0] ps_fix(input logic [2:0] code);
		ps_fix = `MTF_PS_FALLBACK;
		if (code == `MTF_PS_8K || code == `MTF_PS_64K || code == `MTF_PS_4M ||
			code == `MTF_PS_256M) begin
			ps_fix = code;
		end
	endfunction : ps_fix

	// Pointer: base with low bits replaced by entry index
	function automatic logic [63:0] tsb_ptr(input logic [63:0] base, input logic [63:0] va,
		input logic [2:0] ps, input logic second);
		logic [5:0]  shift;
		logic [5:0]  nbits;
		logic [5:0]  mbits;
		logic [63:0] idx;
		logic [63:0] off;
		logic [63:0] mask;
		shift = `MTF_SHIFT_8K;
		unique case (ps)
			`MTF_PS_64K:  shift = `MTF_SHIFT_64K;
			`MTF_PS_4M:   shift = `MTF_SHIFT_4M;
			`MTF_PS_256M: shift = `MTF_SHIFT_256M;
			default:      shift = `MTF_SHIFT_8K;
		endcase
		nbits = `MTF_TSB_IDX_BITS + {2'b00, base[3:0]};
		idx   = (va >> shift) & ((64'h0000_0000_0000_0001 << nbits) - 64'h0000_0000_0000_0001);
		off   = idx << `MTF_TSB_ENT_SHIFT;
		mbits = nbits + `MTF_TSB_ENT_SHIFT + {5'b0_0000, base[`MTF_SPLIT_BIT]};
		if (base[`MTF_SPLIT_BIT] && second) begin
			off = off | (64'h0000_0000_0000_0001 << (nbits + `MTF_TSB_ENT_SHIFT));
		end
		mask    = (64'h0000_0000_0000_0001 << mbits) - 64'h0000_0000_0000_0001;
		tsb_ptr = sext47((base & ~mask) | off);
	endfunction : tsb_ptr

	function automatic mtf_dec_type decode(input logic [7:0] asi, input logic [63:0] va);
		decode = '{kind: MTF_SEL_NONE, idx: 3'h0};
		unique case (asi)
			`MTF_ASI_CTX: begin
				if (va == `MTF_VA_PCTX) decode.kind = MTF_SEL_PCTX;
				if (va == `MTF_VA_SCTX) decode.kind = MTF_SEL_SCTX;
			end
			`MTF_ASI_D_Z_B0:   decode = '{MTF_SEL_BASE, 3'h0};
			`MTF_ASI_D_Z_B1:   decode = '{MTF_SEL_BASE, 3'h1};
			`MTF_ASI_D_NZ_B0:  decode = '{MTF_SEL_BASE, 3'h2};
			`MTF_ASI_D_NZ_B1:  decode = '{MTF_SEL_BASE, 3'h3};
			`MTF_ASI_I_Z_B0:   decode = '{MTF_SEL_BASE, 3'h4};
			`MTF_ASI_I_Z_B1:   decode = '{MTF_SEL_BASE, 3'h5};
			`MTF_ASI_I_NZ_B0:  decode = '{MTF_SEL_BASE, 3'h6};
			`MTF_ASI_I_NZ_B1:  decode = '{MTF_SEL_BASE, 3'h7};
			`MTF_ASI_D_Z_CFG:  decode = '{MTF_SEL_CFG, 3'h0};
			`MTF_ASI_D_NZ_CFG: decode = '{MTF_SEL_CFG, 3'h1};
			`MTF_ASI_I_Z_CFG:  decode = '{MTF_SEL_CFG, 3'h2};
			`MTF_ASI_I_NZ_CFG: decode = '{MTF_SEL_CFG, 3'h3};
			`MTF_ASI_D_MMU:    if (va == `MTF_VA_SYNC_FAULT_STATUS) decode = '{MTF_SEL_SYNC_FAULT_STATUS, 3'h0};
			`MTF_ASI_I_MMU:    if (va == `MTF_VA_SYNC_FAULT_STATUS) decode = '{MTF_SEL_SYNC_FAULT_STATUS, 3'h1};
			`MTF_ASI_D_PTR0:   decode = '{MTF_SEL_PTR, 3'h0};
			`MTF_ASI_D_PTR1:   decode = '{MTF_SEL_PTR, 3'h1};
			`MTF_ASI_I_PTR0:   decode = '{MTF_SEL_PTR, 3'h2};
			`MTF_ASI_I_PTR1:   decode = '{MTF_SEL_PTR, 3'h3};
			default:           decode = '{MTF_SEL_NONE, 3'h0};
		endcase
		if (decode.kind != MTF_SEL_PTR && decode.kind != MTF_SEL_BASE &&
			decode.kind != MTF_SEL_CFG && decode.kind != MTF_SEL_NONE) begin
			decode = decode;
		end else if (decode.kind != MTF_SEL_NONE && va != `MTF_VA_ZERO) begin
			decode.kind = MTF_SEL_NONE;
		end
	endfunction : decode

	// ****************************************************
	// State
	// ****************************************************
	logic [12:0] pctx_reg, pctx_next;
	logic [12:0] sctx_reg, sctx_next;
	logic [63:0] base_reg [0:7];
	logic [63:0] base_next [0:7];
	logic [5:0]  cfg_reg [0:3];
	logic [5:0]  cfg_next [0:3];
	logic [23:0] sync_fault_status_reg [0:1];
	logic [23:0] sync_fault_status_next [0:1];
	logic [63:0] rdata_reg, rdata_next;
	logic        done_reg, done_next;
	logic        mis_reg, mis_next;
	logic        ill_reg, ill_next;

	mtf_dec_type dec;
	logic        misaligned;
	logic        take;
	logic        flt_rec;
	logic [23:0] flt_img;
	logic [7:0]  flt_asi_eff;
	logic [6:0]  flt_ft;
	logic        flt_e;
	logic [63:0] ptr_val;

	assign pctx         = pctx_reg;
	assign sctx         = sctx_reg;
	assign asi_rdata    = rdata_reg;
	assign asi_done     = done_reg;
	assign asi_misalign = mis_reg;
	assign asi_illegal  = ill_reg;

	// ****************************************************
	// Access decode and pointer formation
	// ****************************************************
	always_comb begin
		logic       mmu_i;
		logic       nz;
		logic       sel;
		logic [5:0] cfg;
		mmu_i      = 1'b0;
		nz         = 1'b0;
		sel        = 1'b0;
		cfg        = 6'h00;
		dec        = decode(asi_num, asi_va);
		misaligned = asi_va[2:0] != 3'h0;
		take       = asi_valid && !misaligned && dec.kind != MTF_SEL_NONE &&
			!(asi_write && dec.kind == MTF_SEL_PTR);
		mmu_i = dec.idx[1];
		sel   = dec.idx[0];
		nz    = mmu_i ? (i_tag_ctx != 13'h0000) : (d_tag_ctx != 13'h0000);
		cfg   = cfg_reg[{mmu_i, nz}];
		ptr_val = tsb_ptr(base_reg[{mmu_i, nz, sel}], mmu_i ? i_tag_va : d_tag_va,
			sel ? cfg[5:3] : cfg[2:0], sel);
	end

	// ****************************************************
	// Fault record image
	// ****************************************************
	always_comb begin
		logic fv_old;
		fv_old = sync_fault_status_reg[flt_dmmu ? 1'b0 : 1'b1][`MTF_FV_BIT];
		if (flt_alt) begin
			flt_asi_eff = flt_asi;
		end else if (flt_jmpl_misalign || !flt_tl_nonzero) begin
			flt_asi_eff = flt_cle ? `MTF_ASI_PRIM_LE : `MTF_ASI_PRIM;
		end else begin
			flt_asi_eff = flt_cle ? `MTF_ASI_NUC_LE : `MTF_ASI_NUC;
		end
		if (flt_dmmu) begin
			flt_ft = (flt_trap == MTF_TRAP_ACC_EXC) ? flt_kind : 7'h00;
			flt_e  = !flt_internal && ((flt_asi_eff == `MTF_ASI_RIO) ||
				(flt_asi_eff == `MTF_ASI_RIO_LE) || (flt_bypass ? flt_pa39 : flt_tte_e));
		end else begin
			flt_ft = (flt_trap == MTF_TRAP_ACC_EXC) ? (flt_kind & `MTF_FT_IMMU_MASK)
				: 7'h00;
			flt_e  = 1'b0;
		end
		flt_rec = flt_valid && (flt_trap != MTF_TRAP_MISS) &&
			(flt_trap != MTF_TRAP_REAL_MISS) &&
			(flt_dmmu || flt_trap == MTF_TRAP_ACC_EXC || flt_trap == MTF_TRAP_ACC_ERR);
		flt_img = {flt_asi_eff, 2'b00, flt_ft, flt_e, flt_ctx, 1'b0,
			flt_dmmu && flt_write, fv_old, 1'b1};
	end

	// ****************************************************
	// Next state
	// ****************************************************
	always_comb begin
		pctx_next  = pctx_reg;
		sctx_next  = sctx_reg;
		base_next  = base_reg;
		cfg_next   = cfg_reg;
		sync_fault_status_next  = sync_fault_status_reg;
		rdata_next = 64'h0000_0000_0000_0000;
		done_next  = asi_valid;
		mis_next   = asi_valid && misaligned;
		ill_next   = asi_valid && !misaligned && !take;
		if (take && asi_write) begin
			unique case (dec.kind)
				MTF_SEL_PCTX: pctx_next = asi_wdata[12:0];
				MTF_SEL_SCTX: sctx_next = asi_wdata[12:0];
				MTF_SEL_BASE: base_next[dec.idx] = {asi_wdata[63:13],
					asi_wdata[`MTF_SPLIT_BIT], 8'h00, asi_wdata[3:0]};
				MTF_SEL_CFG: cfg_next[dec.idx[1:0]] = {ps_fix(asi_wdata[10:8]),
					ps_fix(asi_wdata[2:0])};
				MTF_SEL_SYNC_FAULT_STATUS: sync_fault_status_next[dec.idx[0]] = asi_wdata[23:0] & `MTF_SYNC_FAULT_STATUS_MASK &
					(dec.idx[0] ? 24'hff_3fb3 : 24'hff_3ff7);
				default: pctx_next = pctx_reg;
			endcase
		end
		if (flt_rec) begin
			sync_fault_status_next[flt_dmmu ? 1'b0 : 1'b1] = flt_img;
		end
		if (take && !asi_write) begin
			unique case (dec.kind)
				MTF_SEL_PCTX: rdata_next = {51'h0, pctx_reg};
				MTF_SEL_SCTX: rdata_next = {51'h0, sctx_reg};
				MTF_SEL_BASE: rdata_next = sext47(base_reg[dec.idx]);
				MTF_SEL_CFG: rdata_next = {53'h0, cfg_reg[dec.idx[1:0]][5:3], 5'h00,
					cfg_reg[dec.idx[1:0]][2:0]};
				MTF_SEL_SYNC_FAULT_STATUS: rdata_next = {40'h0, sync_fault_status_reg[dec.idx[0]]};
				MTF_SEL_PTR: rdata_next = ptr_val;
				default: rdata_next = 64'h0000_0000_0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pctx_reg  <= 13'h0000;
			sctx_reg  <= 13'h0000;
			base_reg  <= '{default: 64'h0000_0000_0000_0000};
			cfg_reg   <= '{default: 6'h00};
			sync_fault_status_reg  <= '{default: 24'h00_0000};
			rdata_reg <= 64'h0000_0000_0000_0000;
			done_reg  <= 1'b0;
			mis_reg   <= 1'b0;
			ill_reg   <= 1'b0;
		end else begin
			pctx_reg  <= pctx_next;
			sctx_reg  <= sctx_next;
			base_reg  <= base_next;
			cfg_reg   <= cfg_next;
			sync_fault_status_reg  <= sync_fault_status_next;
			rdata_reg <= rdata_next;
			done_reg  <= done_next;
			mis_reg   <= mis_next;
			ill_reg   <= ill_next;
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_overrun;
		flt_rec && sync_fault_status_reg[flt_dmmu ? 1'b0 : 1'b1][0] |=>
			sync_fault_status_reg[$past(flt_dmmu) ? 1'b0 : 1'b1][`MTF_OW_BIT];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun flag not set");

	property p_valid_set;
		flt_rec |=> sync_fault_status_reg[$past(flt_dmmu) ? 1'b0 : 1'b1][`MTF_FV_BIT];
	endproperty
	a_valid_set: assert property (p_valid_set) else $error("fault valid not set");

	property p_miss_keeps;
		flt_valid && flt_trap == MTF_TRAP_MISS && !(asi_valid && asi_write) |=>
			$stable(sync_fault_status_reg[0]) && $stable(sync_fault_status_reg[1]);
	endproperty
	a_miss_keeps: assert property (p_miss_keeps) else $error("miss changed status");

	property p_cfg_fallback;
		take && asi_write && dec.kind == MTF_SEL_CFG && asi_wdata[2:0] == 3'h2 |=>
			cfg_reg[$past(dec.idx[1:0])][2:0] == `MTF_PS_FALLBACK;
	endproperty
	a_cfg_fallback: assert property (p_cfg_fallback) else $error("bad page code kept");

	property p_misalign;
		asi_valid && asi_va[2:0] != 3'h0 |=> asi_misalign && asi_done && !asi_illegal;
	endproperty
	a_misalign: assert property (p_misalign) else $error("misalign not flagged");

	property p_base_sext;
		take && !asi_write && dec.kind == MTF_SEL_BASE |=>
			asi_rdata[63:48] == {16{asi_rdata[47]}} && asi_rdata[11:4] == 8'h00;
	endproperty
	a_base_sext: assert property (p_base_sext) else $error("base read not extended");

	property p_immu_clean;
		sync_fault_status_reg[1][`MTF_E_BIT] == 1'b0 && sync_fault_status_reg[1][`MTF_W_BIT] == 1'b0;
	endproperty
	a_immu_clean: assert property (p_immu_clean) else $error("instr status e or w set");

	property p_immu_ft;
		flt_rec && !flt_dmmu |=> (sync_fault_status_reg[1][13:7] & ~`MTF_FT_IMMU_MASK) == 7'h00;
	endproperty
	a_immu_ft: assert property (p_immu_ft) else $error("instr fault kind out of set");

	property p_base_visible;
		take && asi_write && dec.kind == MTF_SEL_BASE ##1
			(asi_valid && !asi_write && asi_num == $past(asi_num) && asi_va == `MTF_VA_ZERO)
			|=> (asi_rdata >> `MTF_BASE_LSB) == (sext47($past(asi_wdata, 2)) >> `MTF_BASE_LSB);
	endproperty
	a_base_visible: assert property (p_base_visible) else $error("stale base read");

	c_fault_rec: cover property (flt_rec ##1 flt_rec);
	c_sync_fault_status_clear: cover property (take && asi_write && dec.kind == MTF_SEL_SYNC_FAULT_STATUS);
	c_ptr_read: cover property (take && !asi_write && dec.kind == MTF_SEL_PTR);
	c_split_ptr: cover property (take && dec.kind == MTF_SEL_PTR && dec.idx[0] &&
		base_reg[3][`MTF_SPLIT_BIT]);

endmodule : mtf_mmu_regs

// ### rtl/mtf_pkg.sv
// Purpose: Types for the MMU context, TSB and fault status registers
// Assumes: mtf_regs.svh holds the numbers
// Notes:   Index layout of register arrays documented in the block
package mtf_pkg;

	// ****************************************************
	// Trap classes reported with a fault
	// ****************************************************
	typedef enum logic [2:0] {
		MTF_TRAP_MISS,
		MTF_TRAP_REAL_MISS,
		MTF_TRAP_ACC_EXC,
		MTF_TRAP_ACC_ERR,
		MTF_TRAP_OTHER
	} mtf_trap_type;

	// ****************************************************
	// Register targets of an alternate access
	// ****************************************************
	typedef enum logic [2:0] {
		MTF_SEL_NONE,
		MTF_SEL_PCTX,
		MTF_SEL_SCTX,
		MTF_SEL_BASE,
		MTF_SEL_CFG,
		MTF_SEL_SYNC_FAULT_STATUS,
		MTF_SEL_PTR
	} mtf_sel_type;

	typedef struct packed {
		mtf_sel_type kind;
		logic [2:0]  idx;
	} mtf_dec_type;

endpackage : mtf_pkg

// ### rtl/mtf_regs.svh
// Purpose: Constants for the per-strand MMU context, TSB and fault status registers
// Assumes: 64-bit alternate-space load/store port from the core
// Notes:   Offsets, field positions and codes as macros; types live in mtf_pkg
`ifndef MTF_REGS_SVH
`define MTF_REGS_SVH

// ****************************************************
// Address space numbers and offsets
// ****************************************************
`define MTF_ASI_CTX        8'h21
`define MTF_VA_PCTX        64'h0000_0000_0000_0008
`define MTF_VA_SCTX        64'h0000_0000_0000_0010
`define MTF_VA_SYNC_FAULT_STATUS        64'h0000_0000_0000_0018
`define MTF_VA_ZERO        64'h0000_0000_0000_0000
`define MTF_ASI_D_Z_B0     8'h31
`define MTF_ASI_D_Z_B1     8'h32
`define MTF_ASI_D_Z_CFG    8'h33
`define MTF_ASI_D_NZ_B0    8'h39
`define MTF_ASI_D_NZ_B1    8'h3a
`define MTF_ASI_D_NZ_CFG   8'h3b
`define MTF_ASI_I_Z_B0     8'h35
`define MTF_ASI_I_Z_B1     8'h36
`define MTF_ASI_I_Z_CFG    8'h37
`define MTF_ASI_I_NZ_B0    8'h3d
`define MTF_ASI_I_NZ_B1    8'h3e
`define MTF_ASI_I_NZ_CFG   8'h3f
`define MTF_ASI_I_MMU      8'h50
`define MTF_ASI_D_MMU      8'h58
`define MTF_ASI_I_PTR0     8'h51
`define MTF_ASI_I_PTR1     8'h52
`define MTF_ASI_D_PTR0     8'h59
`define MTF_ASI_D_PTR1     8'h5a

// ****************************************************
// Field positions and values
// ****************************************************
`define MTF_CTX_W          13
`define MTF_BASE_LSB       13
`define MTF_SPLIT_BIT      12
`define MTF_SIZE_W         4
`define MTF_SEXT_BIT       47
`define MTF_PS_W           3
`define MTF_PS1_LSB        8
`define MTF_PS0_LSB        0
`define MTF_PS_FALLBACK    3'h5
`define MTF_PS_8K          3'h0
`define MTF_PS_64K         3'h1
`define MTF_PS_4M          3'h3
`define MTF_PS_256M        3'h5
`define MTF_SHIFT_8K       6'h0d
`define MTF_SHIFT_64K      6'h10
`define MTF_SHIFT_4M       6'h16
`define MTF_SHIFT_256M     6'h1c
`define MTF_TSB_IDX_BITS   6'h09
`define MTF_TSB_ENT_SHIFT  6'h04
`define MTF_SYNC_FAULT_STATUS_W         24
`define MTF_SYNC_FAULT_STATUS_MASK      24'hff_3ff7
`define MTF_FT_LSB         7
`define MTF_FT_W           7
`define MTF_E_BIT          6
`define MTF_CT_LSB         4
`define MTF_W_BIT          2
`define MTF_OW_BIT         1
`define MTF_FV_BIT         0
`define MTF_FT_IMMU_MASK   7'h61
`define MTF_ASI_PRIM       8'h80
`define MTF_ASI_PRIM_LE    8'h88
`define MTF_ASI_NUC        8'h04
`define MTF_ASI_NUC_LE     8'h0c
`define MTF_ASI_RIO        8'h15
`define MTF_ASI_RIO_LE     8'h1d

`endif
